// file: rtl/ifsc_map.vh
// Purpose: offsets, fields, reset values and command codes of the flag/command block
// Assumes: byte-wide registers on a plain strobe port
// Notes:   definitions only
`ifndef IFSC_MAP_VH
`define IFSC_MAP_VH

// ************************************************************
// register offsets
// ************************************************************
`define IFSC_OFS_FLAGS      8'h95
`define IFSC_OFS_WAKE       8'h96
`define IFSC_OFS_CMD        8'h97
`define IFSC_OFS_CTRL       8'h98

// ************************************************************
// field positions
// ************************************************************
`define IFSC_BIT_TICK       0
`define IFSC_BIT_PORT       1
`define IFSC_BIT_EXT        2
`define IFSC_BIT_CONV       4
`define IFSC_BIT_TOUCH      5
`define IFSC_BIT_LOWV       7
`define IFSC_BIT_SPALL      0
`define IFSC_BIT_WATCHDOG_TIMEOUT_FLAG       1
`define IFSC_CTRL_RATE_LSB  0
`define IFSC_CTRL_WDP_LSB   4

// ************************************************************
// reset values and command codes
// ************************************************************
`define IFSC_RST_WAKE       8'h00
`define IFSC_RST_RATE       2'h0
`define IFSC_RST_WDP        2'h0
`define IFSC_CMD_SOFTRST    8'h56
`define IFSC_CMD_SPALL      8'h65

// ************************************************************
// last count of each slow tick interval, one less than its length in slow clock cycles; soft reset pulse length less one, in mclk cycles
// ************************************************************
`define IFSC_TICK_0         16'h7fff
`define IFSC_TICK_1         16'h3fff
`define IFSC_TICK_2         16'h1fff
`define IFSC_TICK_3         16'h007f
`define IFSC_SRST_LEN       4'h3

`endif

// file: rtl/ifsc_top.v
// Contract
// - rate select picks 32768/16384/8192/128 slow cycles
// - tick flag sets when interval completes
// - low voltage flag read-only, hardware set
// - touch done flag sets on conversion end only while sysclk_fast_ok is high
// - external edge flag sets on falling edge
// - port change flag sets on enabled pin change
// - three flags auto-clear on service entry
// - wake enable register, one bit per pin
// - writing 56h triggers software reset
// - 65h sets self-program flag, others clear
// - command bit 0 reads self-program flag
// - watchdog period select 480/240/120/60 ms
//
// Purpose: interrupt flag gathering, pin wake enables and system command register
// Assumes: all inputs synchronous to mclk; slow clock arrives as a one-cycle enable
// Notes:   watchdog, converter, touch and flash logic live outside; the slow tick timer is inside
`include "ifsc_map.vh"
`timescale 1ns/1ps
`default_nettype none

module ifsc_top (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        slow_clk_en,
    input  wire        ext_irq_pin,
    input  wire [7:0]  port_pins,
    input  wire        touch_key_done,
    input  wire        sysclk_fast_ok,
    input  wire        conv_done,
    input  wire        low_supply,
    input  wire        watchdog_timeout_flag,
    input  wire        isr_ext_ack,
    input  wire        isr_port_ack,
    input  wire        isr_tick_ack,
    output reg         slow_tick_flag,
    output reg         ext_edge_flag,
    output reg         port_change_flag,
    output reg         touch_done_flag,
    output reg         conv_done_flag,
    output reg         low_voltage_flag,
    output reg  [7:0]  port_wake_enable,
    output reg         self_program_all,
    output reg  [1:0]  watchdog_period_sel,
    output reg         soft_reset_cmd
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    // write hit on one offset, used for every register
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // interval end value for a rate code
    function [15:0] tick_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    tick_last = `IFSC_TICK_0;
                2'h1:    tick_last = `IFSC_TICK_1;
                2'h2:    tick_last = `IFSC_TICK_2;
                default: tick_last = `IFSC_TICK_3;
            endcase
        end
    endfunction

    wire wr_flags = reg_wr && hit(reg_addr, `IFSC_OFS_FLAGS);
    wire wr_wake  = reg_wr && hit(reg_addr, `IFSC_OFS_WAKE);
    wire wr_cmd   = reg_wr && hit(reg_addr, `IFSC_OFS_CMD);
    wire wr_ctrl  = reg_wr && hit(reg_addr, `IFSC_OFS_CTRL);

    // ************************************************************
    // control register: rate select and watchdog period
    // ************************************************************
    reg [1:0] slow_tick_rate_sel;

    // rate select for the slow tick interval
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slow_tick_rate_sel <= `IFSC_RST_RATE;
        end else if (wr_ctrl) begin
            slow_tick_rate_sel <= reg_wdata[`IFSC_CTRL_RATE_LSB +: 2];
        end
    end

    // period select only forwarded; the watchdog itself is outside
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_period_sel <= `IFSC_RST_WDP;
        end else if (wr_ctrl) begin
            watchdog_period_sel <= reg_wdata[`IFSC_CTRL_WDP_LSB +: 2];
        end
    end

    // ************************************************************
    // slow tick timer
    // ************************************************************
    reg  [15:0] tick_cnt_q;
    wire        tick_done = slow_clk_en && (tick_cnt_q >= tick_last(slow_tick_rate_sel));

    // >= so a rate change to a shorter interval never overshoots a wrap
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 16'h0000;
        end else if (slow_clk_en) begin
            if (tick_done) begin
                tick_cnt_q <= 16'h0000;
            end else begin
                tick_cnt_q <= tick_cnt_q + 16'h0001;
            end
        end
    end

    // ************************************************************
    // event detection
    // ************************************************************
    reg        ext_pin_q;
    reg  [7:0] port_pins_q;
    wire [7:0] pin_chg;
    genvar     gi;

    // per-pin change, qualified by that pin's own wake enable
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            assign pin_chg[gi] = (port_pins_q[gi] ^ port_pins[gi]) & port_wake_enable[gi];
        end
    endgenerate

    wire       ext_fall  = ext_pin_q && !ext_irq_pin;
    wire       port_chg  = |pin_chg;
    wire       touch_set = touch_key_done && sysclk_fast_ok;

    // pins assumed synchronous; history starts high so reset is no false edge
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_pin_q   <= 1'b1;
            port_pins_q <= 8'hff;
        end else begin
            ext_pin_q   <= ext_irq_pin;
            port_pins_q <= port_pins;
        end
    end

    // ************************************************************
    // interrupt flags
    // ************************************************************
    // next value of one sticky flag; a set event wins over a clear or a service entry,
    // so an event landing in the clearing cycle is never lost
    function flag_next;
        input set_ev;
        input cur;
        input keep_bit;
        input svc_ack;
        begin
            flag_next = set_ev || (cur && keep_bit && !svc_ack);
        end
    endfunction

    // keep mask: a written zero clears, a one keeps
    wire [7:0] keep = wr_flags ? reg_wdata : 8'hff;

    // tick flag; entry to the tick routine clears it
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slow_tick_flag <= 1'b0;
        end else begin
            slow_tick_flag <= flag_next(tick_done, slow_tick_flag, keep[`IFSC_BIT_TICK], isr_tick_ack);
        end
    end

    // edge flag; set whatever the edge interrupt enable says
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_edge_flag <= 1'b0;
        end else begin
            ext_edge_flag <= flag_next(ext_fall, ext_edge_flag, keep[`IFSC_BIT_EXT], isr_ext_ack);
        end
    end

    // port flag; the port interrupt enable lives outside and has no say here
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_change_flag <= 1'b0;
        end else begin
            port_change_flag <= flag_next(port_chg, port_change_flag, keep[`IFSC_BIT_PORT], isr_port_ack);
        end
    end

    // touch flag; software clear only, no service entry clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            touch_done_flag <= 1'b0;
        end else begin
            touch_done_flag <= flag_next(touch_set, touch_done_flag, keep[`IFSC_BIT_TOUCH], 1'b0);
        end
    end

    // conversion flag; software clear only
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_done_flag <= 1'b0;
        end else begin
            conv_done_flag <= flag_next(conv_done, conv_done_flag, keep[`IFSC_BIT_CONV], 1'b0);
        end
    end

    // low voltage: a plain copy, not sticky; writes cannot touch it
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_voltage_flag <= 1'b0;
        end else begin
            low_voltage_flag <= low_supply;
        end
    end

    // ************************************************************
    // wake enables and system command
    // ************************************************************
    reg [3:0] srst_cnt_q;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_wake_enable <= `IFSC_RST_WAKE;
        end else if (wr_wake) begin
            port_wake_enable <= reg_wdata;
        end
    end

    // reset pulse stretched a few cycles so the reset logic outside sees it
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            self_program_all <= 1'b0;
            soft_reset_cmd   <= 1'b0;
            srst_cnt_q       <= 4'h0;
        end else begin
            if (wr_cmd) begin
                self_program_all <= (reg_wdata == `IFSC_CMD_SPALL);
            end
            if (wr_cmd && reg_wdata == `IFSC_CMD_SOFTRST) begin
                soft_reset_cmd <= 1'b1;
                srst_cnt_q     <= `IFSC_SRST_LEN;
            end else if (srst_cnt_q != 4'h0) begin
                srst_cnt_q <= srst_cnt_q - 4'h1;
            end else begin
                soft_reset_cmd <= 1'b0;
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    reg [7:0] rd_d;

    always @* begin
        rd_d = 8'h00;
        case (reg_addr)
            `IFSC_OFS_FLAGS: begin
                rd_d[`IFSC_BIT_TICK]  = slow_tick_flag;
                rd_d[`IFSC_BIT_PORT]  = port_change_flag;
                rd_d[`IFSC_BIT_EXT]   = ext_edge_flag;
                rd_d[`IFSC_BIT_CONV]  = conv_done_flag;
                rd_d[`IFSC_BIT_TOUCH] = touch_done_flag;
                rd_d[`IFSC_BIT_LOWV]  = low_voltage_flag;
            end
            `IFSC_OFS_WAKE: rd_d = port_wake_enable;
            `IFSC_OFS_CMD: begin
                rd_d[`IFSC_BIT_SPALL] = self_program_all;
                rd_d[`IFSC_BIT_WATCHDOG_TIMEOUT_FLAG]  = watchdog_timeout_flag;
            end
            `IFSC_OFS_CTRL: begin
                rd_d[`IFSC_CTRL_RATE_LSB +: 2] = slow_tick_rate_sel;
                rd_d[`IFSC_CTRL_WDP_LSB +: 2]  = watchdog_period_sel;
            end
            default: rd_d = 8'h00;
        endcase
    end

    // data valid only in the cycle after the read strobe
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // ifsc_top

`default_nettype wire

// file: tb/ifsc_core_mdl.sv
// Purpose: processor core entering service routines
// Assumes: flags {ext, port, tick}, one-cycle acks
// Notes:   one routine at a time, lowest bit first
`timescale 1ns/1ps
`default_nettype none
module ifsc_core_mdl #(parameter int DLY = 3) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       en,
    input  wire logic [2:0] flg,
    output var  logic [2:0] ack
);
    int cnt;
    // vector fetch latency keeps a flag visible for a while
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            ack <= 3'h0;
        end else begin
            ack <= 3'h0;
            cnt <= (en && flg != 3'h0 && ack == 3'h0) ? cnt + 1 : 0;
            if (cnt == DLY) begin
                ack <= flg & (~flg + 3'h1);
                cnt <= 0;
            end
        end
    end
endmodule // ifsc_core_mdl
`default_nettype wire

// file: tb/ifsc_top_sva.sv
// Purpose: port checks for the flag and command block
// Assumes: one clock, async active-low reset
// Notes:   tick counting is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module ifsc_top_sva (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       ext_irq_pin,
    input wire logic [7:0] port_pins,
    input wire logic       watchdog_timeout_flag,
    input wire logic       isr_ext_ack,
    input wire logic       ext_edge_flag,
    input wire logic       port_change_flag,
    input wire logic [7:0] port_wake_enable,
    input wire logic       self_program_all,
    input wire logic       soft_reset_cmd
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // reset request must stand exactly four cycles, then drop
    sequence srst_pulse;
        soft_reset_cmd [*4] ##1 !soft_reset_cmd;
    endsequence
    ext_set_a: assert property ($past(rst_n) && $fell(ext_irq_pin) |=> ext_edge_flag)
        else $error("edge flag missed a falling edge");
    ext_clear_a: assert property ((isr_ext_ack || reg_wr && reg_addr == 8'h95 && !reg_wdata[2])
        && !$fell(ext_irq_pin) |=> !ext_edge_flag) else $error("edge flag not cleared");
    port_set_a: assert property ($past(rst_n) && ((port_pins ^ $past(port_pins)) & port_wake_enable) != 8'h00
        |=> port_change_flag) else $error("port flag missed a change");
    wake_write_a: assert property (reg_wr && reg_addr == 8'h96 |=> port_wake_enable == $past(reg_wdata))
        else $error("wake enable write lost");
    wake_hold_a: assert property (!(reg_wr && reg_addr == 8'h96) |=> $stable(port_wake_enable))
        else $error("wake enable changed unasked");
    spall_write_a: assert property (reg_wr && reg_addr == 8'h97
        |=> self_program_all == ($past(reg_wdata) == 8'h65)) else $error("self program flag wrong");
    soft_reset_a: assert property (reg_wr && reg_addr == 8'h97 && reg_wdata == 8'h56 |=> srst_pulse)
        else $error("soft reset pulse wrong");
    cmd_read_a: assert property (reg_rd && reg_addr == 8'h97
        |=> reg_rdata == {6'h00, $past(watchdog_timeout_flag), $past(self_program_all)})
        else $error("command readback wrong");
endmodule // ifsc_top_sva
bind ifsc_top ifsc_top_sva u_sva (.*);
`default_nettype wire

// file: tb/ifsc_top_tb_top.sv
// Purpose: self-checking bench for the flag and command block
// Assumes: core model services flags when enabled
// Notes:   slow tick run at the shortest rate only
`timescale 1ns/1ps
`default_nettype none
module ifsc_top_tb_top;
    logic       mclk, rst_n, reg_wr, reg_rd, slow_clk_en, ext_irq_pin, touch_key_done;
    logic       sysclk_fast_ok, conv_done, low_supply, watchdog_timeout_flag, core_en;
    logic [7:0] reg_addr, reg_wdata, port_pins;
    wire  [7:0] reg_rdata, port_wake_enable;
    wire  [1:0] watchdog_period_sel;
    wire        isr_ext_ack, isr_port_ack, isr_tick_ack, slow_tick_flag, ext_edge_flag;
    wire        port_change_flag, touch_done_flag, conv_done_flag, low_voltage_flag;
    wire        self_program_all, soft_reset_cmd;
    int         failures = 0, checks = 0, n;
    ifsc_top uut (.*);
    ifsc_core_mdl core (.mclk(mclk), .rst_n(rst_n), .en(core_en),
        .flg({ext_edge_flag, port_change_flag, slow_tick_flag}),
        .ack({isr_ext_ack, isr_port_ack, isr_tick_ack}));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic svc;
        @(posedge mclk) core_en <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(8'h95, 8'h00);
        core_en <= 1'b0;
    endtask
    task automatic t_tick;
        wr(8'h98, 8'h33);
        rd(8'h98, 8'h33);
        chk({6'h00, watchdog_period_sel}, 8'h03);
        repeat (127) @(posedge mclk) slow_clk_en <= 1'b1;
        @(posedge mclk) slow_clk_en <= 1'b0;
        rd(8'h95, 8'h00);
        @(posedge mclk) slow_clk_en <= 1'b1;
        @(posedge mclk) slow_clk_en <= 1'b0;
        rd(8'h95, 8'h01);
        chk({7'h00, slow_tick_flag}, 8'h01);
        wr(8'h95, 8'hfe);
        rd(8'h95, 8'h00);
        $display("tick test done");
    endtask
    task automatic t_ext;
        @(posedge mclk) ext_irq_pin <= 1'b0;
        rd(8'h95, 8'h04);
        chk({7'h00, ext_edge_flag}, 8'h01);
        wr(8'h95, 8'hfb);
        rd(8'h95, 8'h00);
        @(posedge mclk) ext_irq_pin <= 1'b1;
        @(posedge mclk) ext_irq_pin <= 1'b0;
        wr(8'h95, 8'hfe);
        rd(8'h95, 8'h04);
        svc;
        ext_irq_pin <= 1'b1;
        $display("edge test done");
    endtask
    task automatic t_port;
        rd(8'h96, 8'h00);
        @(posedge mclk) port_pins <= 8'h01;
        rd(8'h95, 8'h00);
        wr(8'h96, 8'h01);
        rd(8'h96, 8'h01);
        @(posedge mclk) port_pins <= 8'h03;
        rd(8'h95, 8'h00);
        @(posedge mclk) port_pins <= 8'h02;
        rd(8'h95, 8'h02);
        chk({7'h00, port_change_flag}, 8'h01);
        wr(8'h95, 8'hfd);
        rd(8'h95, 8'h00);
        @(posedge mclk) port_pins <= 8'h03;
        svc;
        $display("port test done");
    endtask
    task automatic t_misc;
        @(posedge mclk) touch_key_done <= 1'b1;
        @(posedge mclk) touch_key_done <= 1'b0;
        rd(8'h95, 8'h00);
        sysclk_fast_ok <= 1'b1;
        touch_key_done <= 1'b1;
        conv_done      <= 1'b1;
        @(posedge mclk) touch_key_done <= 1'b0;
        conv_done <= 1'b0;
        rd(8'h95, 8'h30);
        chk({2'h0, touch_done_flag, conv_done_flag, 4'h0}, 8'h30);
        low_supply <= 1'b1;
        wr(8'h95, 8'h00);
        rd(8'h95, 8'h80);
        chk({7'h00, low_voltage_flag}, 8'h01);
        low_supply <= 1'b0;
        $display("flag test done");
    endtask
    task automatic t_cmd;
        rd(8'h97, 8'h02);
        wr(8'h97, 8'h65);
        rd(8'h97, 8'h03);
        wr(8'h97, 8'h12);
        rd(8'h97, 8'h02);
        rd(8'h50, 8'h00);
        wr(8'h97, 8'h56);
        n = 0;
        repeat (8) begin
            #1 n += soft_reset_cmd;
            @(posedge mclk);
        end
        chk(n[7:0], 8'h04);
        $display("command test done");
    endtask
    task automatic end_sim;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, slow_clk_en, touch_key_done, sysclk_fast_ok} = 6'h00;
        {conv_done, low_supply, core_en, reg_addr, reg_wdata, port_pins} = 27'h0;
        ext_irq_pin = 1'b1;
        watchdog_timeout_flag = 1'b1;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_tick;
        t_ext;
        t_port;
        t_misc;
        t_cmd;
        end_sim;
    end
    // hang guard, far beyond the few hundred cycles used
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        end_sim;
    end
endmodule // ifsc_top_tb_top
`default_nettype wire
